// *** rtl/mps_frame_scheduler.v ***
// Frame-synchronous thread scheduler with frame trigger, PWM pairs and brake.
// How it works
// - Running thread finishes before next one starts.
// - Every thread chain ends within one frame.
// - Activity pins high exactly while thread runs.
// - Trigger rises at frame start, falls centre.
// - Speed loop runs every fourth frame.
// - Current loop is two consecutive threads.
// - PWM master short service then later update.
// - Three centre-aligned pairs, base channel negated.
// - Frame period is fifty microseconds.
// - Brake compares bus voltage on its request.
// - Trigger links speed, speed links brake.
// - Second trigger thread links observer, current loop.
// - Current loop then links PWM master short service.
// - Late chain defers update to next frame.
// - Update starts a lead time before frame end.
// - Fractions are signed 1.23 format.
// - Voltage vector uses signed 3.21 format.
// - Fraction equals value over full-scale range.
// - Frame counter toggles resolver excitation at quarter and frame end.
// - Brake duty ramps linearly between thresholds.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_frame_scheduler (
  input wire CLK,
  input wire RESETN,
  input wire CE,
  input wire [`MPS_CNT_W-1:0] UPDATE_LEAD,
  input wire [`MPS_W-1:0] U_DC_BUS,
  input wire [`MPS_W-1:0] U_DC_OFF,
  input wire [`MPS_W-1:0] U_DC_ON,
  input wire [`MPS_W-1:0] V_ALPHA,
  input wire [`MPS_W-1:0] V_BETA,
  output reg FRAME_TRIGGER,
  output reg RESOLVER_EXCITATION,
  output reg ACT_SPEED_LOOP,
  output reg ACT_CURRENT_LOOP,
  output reg ACT_PWM_MASTER,
  output wire BRAKE_OUT,
  output wire [2:0] PWM_BASE_N,
  output wire [2:0] PWM_COMP,
  output reg UPDATE_DEFERRED
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_TRIG1 = 4'h1;
  localparam [3:0] ST_SPEED = 4'h2;
  localparam [3:0] ST_BRAKE = 4'h3;
  localparam [3:0] ST_TRIG2 = 4'h4;
  localparam [3:0] ST_OBS = 4'h5;
  localparam [3:0] ST_CL1 = 4'h6;
  localparam [3:0] ST_CL2 = 4'h7;
  localparam [3:0] ST_PWM_SHORT = 4'h8;
  localparam [3:0] ST_PWM_LONG = 4'h9;
  localparam [3:0] ST_CL_GAP = 4'hA;

  reg [`MPS_CNT_W-1:0] cnt;
  reg [1:0] frame_div;
  reg [3:0] state;
  reg [15:0] busy;
  reg trig2_pend;
  reg upd_pend;
  reg trig1_pend;
  reg upd_ready;
  reg chain_done;
  reg [`MPS_W-1:0] v_alpha_q;
  reg [`MPS_W-1:0] v_beta_q;
  reg [`MPS_CNT_W-1:0] duty_a;
  reg [`MPS_CNT_W-1:0] duty_b;
  reg [`MPS_CNT_W-1:0] duty_c;
  reg [`MPS_CNT_W-1:0] next_da;
  reg [`MPS_CNT_W-1:0] next_db;
  reg [`MPS_CNT_W-1:0] next_dc;
  reg [`MPS_CNT_W-1:0] pend_a;
  reg [`MPS_CNT_W-1:0] pend_b;
  reg [`MPS_CNT_W-1:0] pend_c;
  reg brake_update;
  wire frame_start;
  wire frame_last;
  wire at_centre;
  wire at_quarter;
  wire at_update;
  wire [`MPS_CNT_W-1:0] tri_pos;
  wire thread_end;
  wire [`MPS_CNT_W-1:0] half;
  wire signed [`MPS_W-1:0] va;
  wire signed [`MPS_W-1:0] vb;
  wire signed [`MPS_W+1:0] ph_b;
  wire signed [`MPS_W+1:0] ph_c;

  assign frame_last = (cnt == `MPS_FRAME_CYC - 13'h0001);
  assign frame_start = (cnt == 13'h0000);
  assign at_centre = (cnt == `MPS_HALF_CYC);
  assign at_quarter = (cnt == `MPS_QUARTER_CYC);
  assign at_update = (cnt == `MPS_FRAME_CYC - UPDATE_LEAD);
  assign half = `MPS_HALF_CYC;
  assign tri_pos = (cnt < half) ? (half - cnt) : (cnt - half);
  assign thread_end = (busy == 16'h0001);
  assign va = v_alpha_q;
  assign vb = v_beta_q;
  // Inverse Clarke of the 3.21 vector; b and c phases carry half-weight terms.
  assign ph_b = -($signed({{2{va[`MPS_W-1]}}, va}) >>> 1) + (($signed({{2{vb[`MPS_W-1]}}, vb})
    * 26'sd7) >>> 3);
  assign ph_c = -($signed({{2{va[`MPS_W-1]}}, va}) >>> 1) - (($signed({{2{vb[`MPS_W-1]}}, vb})
    * 26'sd7) >>> 3);

  // A 3.21 value spans -4..4; map it onto duty around half the frame.
  function [`MPS_CNT_W-1:0] to_duty;
    input signed [`MPS_W+1:0] v;
    reg signed [`MPS_W+15:0] scaled;
    reg signed [`MPS_W+15:0] d;
    begin
      scaled = ($signed({{14{v[`MPS_W+1]}}, v}) * 40'sd312) >>> 21;
      d = scaled + 40'sd1250;
      if (d < 40'sd0)
        to_duty = 13'h0000;
      else if (d > 40'sd2500)
        to_duty = `MPS_HALF_CYC;
      else
        to_duty = d[`MPS_CNT_W-1:0];
    end
  endfunction

  always @*
  begin
    next_da = to_duty({{2{va[`MPS_W-1]}}, va});
    next_db = to_duty(ph_b);
    next_dc = to_duty(ph_c);
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cnt <= 13'h0000;
      frame_div <= 2'h0;
      FRAME_TRIGGER <= 1'b0;
      RESOLVER_EXCITATION <= 1'b0;
    end
    else if (CE)
    begin
      if (frame_last)
      begin
        cnt <= 13'h0000;
        frame_div <= frame_div + 2'h1;
      end
      else
        cnt <= cnt + 13'h0001;
      if (frame_start)
        FRAME_TRIGGER <= 1'b1;
      else if (at_centre)
        FRAME_TRIGGER <= 1'b0;
      if (at_quarter || frame_last)
        RESOLVER_EXCITATION <= ~RESOLVER_EXCITATION;
    end
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= ST_IDLE;
      busy <= 16'h0000;
      trig2_pend <= 1'b0;
      upd_pend <= 1'b0;
      chain_done <= 1'b0;
      trig1_pend <= 1'b0;
      upd_ready <= 1'b0;
      ACT_SPEED_LOOP <= 1'b0;
      ACT_CURRENT_LOOP <= 1'b0;
      ACT_PWM_MASTER <= 1'b0;
      UPDATE_DEFERRED <= 1'b0;
      brake_update <= 1'b0;
      v_alpha_q <= 24'h00_0000;
      v_beta_q <= 24'h00_0000;
      // A zero vector sits at the quarter count, which is half duty on the centred triangle.
      duty_a <= `MPS_QUARTER_CYC;
      duty_b <= `MPS_QUARTER_CYC;
      duty_c <= `MPS_QUARTER_CYC;
      pend_a <= `MPS_QUARTER_CYC;
      pend_b <= `MPS_QUARTER_CYC;
      pend_c <= `MPS_QUARTER_CYC;
    end
    else if (CE)
    begin
      brake_update <= 1'b0;
      if (frame_start)
      begin
        chain_done <= 1'b0;
        // The frame start waits here if a thread still runs, instead of being lost.
        trig1_pend <= 1'b1;
        // Only values that a started update accepted are applied.
        if (upd_ready)
        begin
          upd_ready <= 1'b0;
          duty_a <= pend_a;
          duty_b <= pend_b;
          duty_c <= pend_c;
        end
      end
      if (at_quarter)
        trig2_pend <= 1'b1;
      if (at_update)
        upd_pend <= 1'b1;
      if (busy > 16'h0001)
        busy <= busy - 16'h0001;
      else
      begin
        busy <= 16'h0000;
        ACT_SPEED_LOOP <= 1'b0;
        ACT_CURRENT_LOOP <= 1'b0;
        ACT_PWM_MASTER <= 1'b0;
        case (state)
          ST_IDLE:
          begin
            if ((frame_start || trig1_pend) && !thread_end)
            begin
              trig1_pend <= 1'b0;
              state <= ST_TRIG1;
              busy <= `MPS_T_TRIG1;
            end
            else if (trig2_pend)
            begin
              trig2_pend <= 1'b0;
              state <= ST_TRIG2;
              busy <= `MPS_T_TRIG2;
            end
            else if (upd_pend)
            begin
              upd_pend <= 1'b0;
              if (chain_done)
              begin
                state <= ST_PWM_LONG;
                busy <= `MPS_T_PWM_LONG;
                ACT_PWM_MASTER <= 1'b1;
                UPDATE_DEFERRED <= 1'b0;
                upd_ready <= 1'b1;
              end
              else
                UPDATE_DEFERRED <= 1'b1;
            end
          end
          ST_TRIG1:
          begin
            if (frame_div == 2'h0)
            begin
              state <= ST_SPEED;
              busy <= `MPS_T_SPEED;
              ACT_SPEED_LOOP <= 1'b1;
            end
            else
              state <= ST_IDLE;
          end
          ST_SPEED:
          begin
            state <= ST_BRAKE;
            busy <= `MPS_T_BRAKE;
            brake_update <= 1'b1;
          end
          ST_BRAKE:
            state <= ST_IDLE;
          ST_TRIG2:
          begin
            v_alpha_q <= V_ALPHA;
            v_beta_q <= V_BETA;
            state <= ST_OBS;
            busy <= `MPS_T_OBS;
          end
          ST_OBS:
          begin
            state <= ST_CL1;
            busy <= `MPS_T_CL1;
            ACT_CURRENT_LOOP <= 1'b1;
          end
          ST_CL1:
            state <= ST_CL_GAP;
          // One dispatch cycle between the two threads keeps their pulses apart.
          ST_CL_GAP:
          begin
            state <= ST_CL2;
            busy <= `MPS_T_CL2;
            ACT_CURRENT_LOOP <= 1'b1;
          end
          ST_CL2:
          begin
            state <= ST_PWM_SHORT;
            busy <= `MPS_T_PWM_SHORT;
            ACT_PWM_MASTER <= 1'b1;
          end
          ST_PWM_SHORT:
          begin
            pend_a <= next_da;
            pend_b <= next_db;
            pend_c <= next_dc;
            chain_done <= 1'b1;
            state <= ST_IDLE;
          end
          ST_PWM_LONG:
            state <= ST_IDLE;
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  mps_pwm_pair u_pair_a (
    .clk(CLK), .resetn(RESETN), .ce(CE), .tri_pos(tri_pos), .duty(duty_a),
    .base_n(PWM_BASE_N[0]), .comp(PWM_COMP[0])
  );
  mps_pwm_pair u_pair_b (
    .clk(CLK), .resetn(RESETN), .ce(CE), .tri_pos(tri_pos), .duty(duty_b),
    .base_n(PWM_BASE_N[1]), .comp(PWM_COMP[1])
  );
  mps_pwm_pair u_pair_c (
    .clk(CLK), .resetn(RESETN), .ce(CE), .tri_pos(tri_pos), .duty(duty_c),
    .base_n(PWM_BASE_N[2]), .comp(PWM_COMP[2])
  );
  mps_brake_pwm u_brake (
    .clk(CLK), .resetn(RESETN), .ce(CE), .update(brake_update), .u_dc(U_DC_BUS),
    .u_off(U_DC_OFF), .u_on(U_DC_ON), .cnt(cnt), .brake(BRAKE_OUT)
  );
endmodule
`default_nettype wire

// *** rtl/mps_regs.vh ***
// Constants for the motor PWM frame scheduler.
`ifndef MPS_REGS_VH
`define MPS_REGS_VH
`define MPS_CLK_MHZ 100
`define MPS_FRAME_NS 50000
`define MPS_FRAME_CYC 13'h1388
`define MPS_HALF_CYC 13'h09C4
`define MPS_QUARTER_CYC 13'h04E2
`define MPS_SPEED_DIV 4
`define MPS_W 24
`define MPS_CNT_W 13
`define MPS_FRAC_MIN 24'h80_0000
`define MPS_FRAC_MAX 24'h7F_FFFF
`define MPS_T_TRIG1 16'h0008
`define MPS_T_SPEED 16'h0020
`define MPS_T_BRAKE 16'h0010
`define MPS_T_TRIG2 16'h0018
`define MPS_T_OBS 16'h0018
`define MPS_T_CL1 16'h0028
`define MPS_T_CL2 16'h0028
`define MPS_T_PWM_SHORT 16'h0010
`define MPS_T_PWM_LONG 16'h0020
`define MPS_LEAD_DEFAULT 13'h0190
`endif

// *** rtl/mps_pwm_pair.v ***
// One centre-aligned complementary PWM pair driven from the frame counter.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_pwm_pair (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [`MPS_CNT_W-1:0] tri_pos,
  input wire [`MPS_CNT_W-1:0] duty,
  output reg base_n,
  output reg comp
);
  wire on;
  // Centre alignment: high while the triangle sits below the duty value.
  assign on = (tri_pos < duty);
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_n <= 1'b1;
      comp <= 1'b0;
    end
    else if (ce)
    begin
      base_n <= ~on;
      // The low-side switch takes the opposite state, so a leg never conducts through both.
      comp <= ~on;
    end
  end
endmodule
`default_nettype wire

// *** rtl/mps_brake_pwm.v ***
// Brake output with a linear duty ramp between two DC-bus thresholds.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_brake_pwm (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire update,
  input wire [`MPS_W-1:0] u_dc,
  input wire [`MPS_W-1:0] u_off,
  input wire [`MPS_W-1:0] u_on,
  input wire [`MPS_CNT_W-1:0] cnt,
  output reg brake
);
  reg [`MPS_CNT_W-1:0] duty;
  reg [`MPS_CNT_W:0] next_duty;
  reg [47:0] prod;
  reg [47:0] quot;
  reg [`MPS_W:0] span;
  reg [`MPS_W:0] diff;
  always @*
  begin
    span = {u_on[`MPS_W-1], u_on} - {u_off[`MPS_W-1], u_off};
    diff = {u_dc[`MPS_W-1], u_dc} - {u_off[`MPS_W-1], u_off};
    prod = 48'h0000_0000_0000;
    quot = 48'h0000_0000_0000;
    next_duty = {1'b0, duty};
    if ($signed(u_dc) <= $signed(u_off))
      next_duty = 14'h0000;
    else if ($signed(u_dc) >= $signed(u_on))
      next_duty = {1'b0, `MPS_FRAME_CYC};
    else
    begin
      // Inside the ramp both differences are positive and diff is below span.
      prod = {23'h00_0000, diff} * {35'h0_0000_0000, `MPS_FRAME_CYC};
      quot = prod / {23'h00_0000, span};
      next_duty = quot[`MPS_CNT_W:0];
    end
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      duty <= 13'h0000;
      brake <= 1'b0;
    end
    else if (ce)
    begin
      if (update)
        duty <= next_duty[`MPS_CNT_W-1:0];
      brake <= (cnt < duty);
    end
  end
endmodule
`default_nettype wire

// *** verification/mps_sched_chk.sv ***
// Checker of frame timing and thread activity at the scheduler ports.
`timescale 1ns/100ps
`default_nettype none
module mps_sched_chk (
  input wire CLK,
  input wire RESETN,
  input wire FRAME_TRIGGER,
  input wire RESOLVER_EXCITATION,
  input wire ACT_SPEED_LOOP,
  input wire ACT_CURRENT_LOOP,
  input wire ACT_PWM_MASTER,
  input wire BRAKE_OUT,
  input wire [2:0] PWM_BASE_N,
  input wire [2:0] PWM_COMP
);
  reg pt;
  reg pe;
  reg ps;
  reg pc;
  reg seen;
  reg seen_sp;
  reg rst_held;
  reg [12:0] cnt;
  reg [12:0] pos;
  reg [2:0] tr;
  reg [1:0] cl;
  wire rise = FRAME_TRIGGER && !pt;
  wire sp_rise = ACT_SPEED_LOOP && !ps;
  wire cl_rise = ACT_CURRENT_LOOP && !pc;
  // Helpers restart with reset, so no check leans on a frame begun before it.
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      {pt, pe, ps, pc, seen, seen_sp} <= 6'h00;
      rst_held <= 1'b1;
      cnt <= 13'h0000;
      pos <= 13'h0000;
      tr <= 3'h0;
      cl <= 2'h0;
    end
    else
    begin
      {pt, pe, ps, pc} <= {FRAME_TRIGGER, RESOLVER_EXCITATION, ACT_SPEED_LOOP, ACT_CURRENT_LOOP};
      rst_held <= 1'b0;
      cnt <= (FRAME_TRIGGER != pt) ? 13'h0000 : cnt + 13'h0001;
      pos <= rise ? 13'h0001 : pos + 13'h0001;
      seen <= seen | rise;
      seen_sp <= seen_sp | sp_rise;
      tr <= sp_rise ? 3'h0 : tr + {2'h0, rise};
      cl <= rise ? 2'h0 : cl + {1'b0, cl_rise};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_trig_half: assert property ((FRAME_TRIGGER != pt) && seen |-> cnt == 13'd2499)
    else $error("frame trigger half period wrong");
  a_frame_cl: assert property (rise && seen |-> cl == 2'h2)
    else $error("current loop pulse count per frame wrong");
  a_speed_div: assert property (sp_rise |-> pos <= 13'd16 && (!seen_sp || tr == 3'h4))
    else $error("speed loop not at start of every fourth frame");
  a_speed_len: assert property ($rose(ACT_SPEED_LOOP) |->
    (ACT_SPEED_LOOP throughout (##31 1)) ##1 !ACT_SPEED_LOOP)
    else $error("speed loop pulse length wrong");
  a_cl_len: assert property ($rose(ACT_CURRENT_LOOP) |-> ##39 ACT_CURRENT_LOOP ##1 $fell(ACT_CURRENT_LOOP))
    else $error("current loop thread length wrong");
  a_pwm_len: assert property ($rose(ACT_PWM_MASTER) |-> ##15 ACT_PWM_MASTER ##1
    (!ACT_PWM_MASTER or (1 ##16 !ACT_PWM_MASTER)))
    else $error("pwm master pulse length wrong");
  a_one_thread: assert property ($onehot0({ACT_SPEED_LOOP, ACT_CURRENT_LOOP, ACT_PWM_MASTER}))
    else $error("two threads active at once");
  a_exc_edge: assert property ((RESOLVER_EXCITATION != pe) && seen |->
    (pos >= 13'd1249 && pos <= 13'd1252) || pos >= 13'd4997 || pos <= 13'd1)
    else $error("resolver excitation edge out of place");
  // Looks only once reset has acted on the outputs, so power-up unknowns do not count.
  a_reset_idle: assert property (disable iff (1'b0) !RESETN && rst_held |->
    !FRAME_TRIGGER && !BRAKE_OUT && PWM_BASE_N == 3'h7 && PWM_COMP == 3'h0)
    else $error("outputs not idle in reset");
endmodule
`default_nettype wire

// *** verification/mps_stage_model.sv ***
// Power stage and converter model: samples bus voltage, watches for shoot-through.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_stage_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic trig,
  input wire logic [`MPS_W-1:0] level,
  input wire logic [2:0] base_n,
  input wire logic [2:0] comp,
  output logic [`MPS_W-1:0] u_dc,
  output logic shoot
);
  logic pt;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pt <= 1'b0;
      u_dc <= 24'h00_0000;
      shoot <= 1'b0;
    end
    else
    begin
      pt <= trig;
      if (trig && !pt)
        u_dc <= level;
      // Both switches of one leg on would short the bus.
      if ((~base_n & comp) != 3'h0)
        shoot <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench of the motor PWM frame scheduler.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_tests = n_tests + 1; \
    if ((a) !== (b)) \
    begin \
      err_count = err_count + 1; \
      $display("FAIL t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module testbench;
  reg CLK = 1'b0;
  reg RESETN = 1'b0;
  reg CE = 1'b0;
  reg [12:0] UPDATE_LEAD = 13'h0190;
  reg [23:0] LEVEL = 24'h20_0000;
  reg [23:0] U_DC_OFF = 24'h40_0000;
  reg [23:0] U_DC_ON = 24'h60_0000;
  reg [23:0] V_ALPHA = 24'h00_0000;
  reg [23:0] V_BETA = 24'h00_0000;
  wire [23:0] U_DC_BUS;
  wire FRAME_TRIGGER, RESOLVER_EXCITATION, ACT_SPEED_LOOP, ACT_CURRENT_LOOP;
  wire ACT_PWM_MASTER, BRAKE_OUT, UPDATE_DEFERRED, SHOOT;
  wire [2:0] PWM_BASE_N;
  wire [2:0] PWM_COMP;
  int err_count = 0;
  int n_tests = 0;
  int per, th, bh, ph;
  always #5 CLK = ~CLK;
  mps_frame_scheduler i_dut (.CLK(CLK), .RESETN(RESETN), .CE(CE), .UPDATE_LEAD(UPDATE_LEAD),
    .U_DC_BUS(U_DC_BUS), .U_DC_OFF(U_DC_OFF), .U_DC_ON(U_DC_ON), .V_ALPHA(V_ALPHA),
    .V_BETA(V_BETA), .FRAME_TRIGGER(FRAME_TRIGGER), .RESOLVER_EXCITATION(RESOLVER_EXCITATION),
    .ACT_SPEED_LOOP(ACT_SPEED_LOOP), .ACT_CURRENT_LOOP(ACT_CURRENT_LOOP),
    .ACT_PWM_MASTER(ACT_PWM_MASTER), .BRAKE_OUT(BRAKE_OUT), .PWM_BASE_N(PWM_BASE_N),
    .PWM_COMP(PWM_COMP), .UPDATE_DEFERRED(UPDATE_DEFERRED));
  mps_stage_model i_stage (.clk(CLK), .resetn(RESETN), .trig(FRAME_TRIGGER), .level(LEVEL),
    .base_n(PWM_BASE_N), .comp(PWM_COMP), .u_dc(U_DC_BUS), .shoot(SHOOT));
  task give_verdict;
    begin
      $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Counts one frame from a trigger rise to the next one.
  task frame;
    reg p;
    begin
      p = FRAME_TRIGGER;
      repeat (6000)
      begin
        @(posedge CLK);
        #1;
        if (FRAME_TRIGGER && !p)
          break;
        p = FRAME_TRIGGER;
      end
      p = 1'b1;
      per = 0;
      th = 0;
      bh = 0;
      ph = 0;
      repeat (5100)
      begin
        @(posedge CLK);
        #1;
        per++;
        th += FRAME_TRIGGER;
        bh += BRAKE_OUT;
        ph += !PWM_BASE_N[0];
        if (FRAME_TRIGGER && !p)
          break;
        p = FRAME_TRIGGER;
      end
    end
  endtask
  task t_reset;
    begin
      `CHK(PWM_BASE_N, 3'h7);
      `CHK({FRAME_TRIGGER, BRAKE_OUT, PWM_COMP}, 5'h00);
    end
  endtask
  task t_period;
    begin
      frame;
      `CHK(per, 5000);
      `CHK(th, 2500);
      `CHK(bh, 0);
      // A zero vector gives the high side about half of the frame.
      `CHK(ph >= 2490 && ph <= 2510, 1'b1);
      `CHK(UPDATE_DEFERRED, 1'b0);
    end
  endtask
  task t_brake(input reg [23:0] lvl, input int lo, input int hi);
    begin
      @(posedge CLK);
      LEVEL <= lvl;
      // The stage samples at the next frame start; the next speed thread then asks the brake.
      @(posedge FRAME_TRIGGER);
      @(negedge ACT_SPEED_LOOP);
      frame;
      `CHK(bh >= lo && bh <= hi, 1'b1);
    end
  endtask
  task t_defer;
    begin
      @(posedge CLK);
      UPDATE_LEAD <= 13'h1300;
      repeat (12000)
      begin
        @(posedge CLK);
        #1;
        if (UPDATE_DEFERRED === 1'b1)
          break;
      end
      `CHK(UPDATE_DEFERRED, 1'b1);
      `CHK(SHOOT, 1'b0);
    end
  endtask
  initial
  begin
    @(posedge CLK);
    #1;
    t_reset;
    @(posedge CLK);
    RESETN <= 1'b1;
    CE <= 1'b1;
    t_period;
    t_brake(24'h70_0000, 5000, 5000);
    t_brake(24'h50_0000, 2500, 2500);
    t_defer;
    give_verdict;
  end
  // The whole run needs about ten frames; this limit adds a fifth as margin.
  initial
  begin
    #600000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule
bind mps_frame_scheduler mps_sched_chk i_chk (.CLK(CLK), .RESETN(RESETN),
  .FRAME_TRIGGER(FRAME_TRIGGER), .RESOLVER_EXCITATION(RESOLVER_EXCITATION),
  .ACT_SPEED_LOOP(ACT_SPEED_LOOP), .ACT_CURRENT_LOOP(ACT_CURRENT_LOOP),
  .ACT_PWM_MASTER(ACT_PWM_MASTER), .BRAKE_OUT(BRAKE_OUT), .PWM_BASE_N(PWM_BASE_N),
  .PWM_COMP(PWM_COMP));
`default_nettype wire
